// ===== logic/orac_ctrl.sv
// On-chip RAM access control: window decode, enable gating, system control.
//
// Overview of operation
// R1: The RAM sits on a 16-bit data path for byte and word accesses.
// R2: A byte access takes two states with the byte on data lines 15 to 8.
// R3: A word access from an even address takes two states on all 16 lines.
// R4: Control bit 0 disables the RAM at 0, enables it at 1, and resets to 1.
// R5: That bit reloads on a rising clear input edge and holds in standby.
// R6: With the bit set, window accesses use RAM; modes 1, 5, 7 end at FFF0F.
// R7: Mode 3 has a 24-bit window to FFFF0F, mode 6 a 16-bit one to FF0F.
// R8: In modes 1, 3 and 5 with the bit clear, the window goes external.
// R9: In modes 6 and 7 with the bit clear, reads are all ones, writes dropped.
// R10: The control register sits at FFF2, is read-write and resets to 0B.
// R11: Decode and gating use the enable bit as it stands in the access cycle.
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module orac_ctrl (
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave for the system control register.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Pins.
  input  wire logic        hardware_clear_input_n,
  input  wire logic [2:0]  mode_pins,
  input  wire logic        standby,
  // CPU internal bus.
  input  wire logic        cpu_req,
  input  wire logic        cpu_write,
  input  wire logic        cpu_word,
  input  wire logic [23:0] cpu_addr,
  input  wire logic [15:0] cpu_wdata,
  output logic      [15:0] cpu_rdata,
  output logic             cpu_ack,
  output logic             cpu_ext
);
  import orac_pkg::*;

  // ----------------------------------------------------------------------
  // Window decode.
  // ----------------------------------------------------------------------
  // Returns whether an address lies in the RAM window of the given mode.
  function automatic logic in_window(input orac_mode_t m,
                                     input logic [23:0] a);
    logic hit;
    hit = 1'b0;
    case (m)
      ORAC_MODE_1, ORAC_MODE_5, ORAC_MODE_7: begin
        hit = (a[19:0] >= ORAC_M157_BASE) && (a[19:0] <= ORAC_M157_TOP);
      end
      ORAC_MODE_3: begin
        hit = (a >= ORAC_M3_BASE) && (a <= ORAC_M3_TOP);
      end
      ORAC_MODE_6: begin
        hit = (a[15:0] >= ORAC_M6_BASE) && (a[15:0] <= ORAC_M6_TOP);
      end
      default: begin
        hit = 1'b0;
      end
    endcase
    return hit;
  endfunction

  // ----------------------------------------------------------------------
  // Pin synchronisers.
  // ----------------------------------------------------------------------
  logic       clr_meta;
  logic       clr_sync;
  logic       clr_prev;
  logic       stby_meta;
  logic       stby_sync;
  logic [2:0] mode_meta;
  logic [2:0] mode_sync;

  // Pins are asynchronous; two flops before anything reads them. The clear
  // chain resets to the pin's idle high level, so that leaving reset does
  // not look like a clear edge and wipe an early register write.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clr_meta  <= 1'b1;
      clr_sync  <= 1'b1;
      clr_prev  <= 1'b1;
      stby_meta <= 1'b0;
      stby_sync <= 1'b0;
      mode_meta <= 3'b000;
      mode_sync <= 3'b000;
    end else begin
      clr_meta  <= hardware_clear_input_n;
      clr_sync  <= clr_meta;
      clr_prev  <= clr_sync;
      stby_meta <= standby;
      stby_sync <= stby_meta;
      mode_meta <= mode_pins;
      mode_sync <= mode_meta;
    end
  end

  wire        clr_rise = clr_sync && !clr_prev;
  orac_mode_t mode;
  assign mode = orac_mode_t'(mode_sync);

  // ----------------------------------------------------------------------
  // System control register over APB.
  // ----------------------------------------------------------------------
  logic [7:0]  system_control;
  logic [31:0] next_prdata;

  wire reg_hit    = (paddr == ORAC_SYSCTL_ADDR);
  wire apb_setup  = psel && !penable;
  wire apb_access = psel && penable;
  wire apb_write  = apb_access && pwrite && reg_hit;
  wire onchip_memory_enable = system_control[ORAC_ENABLE_BIT]; // [R4]

  // Zero wait states; an unmapped address answers with an error.
  assign pready  = 1'b1;
  assign pslverr = apb_access && !reg_hit;
  assign next_prdata = reg_hit ? {24'h000000, system_control} : 32'h0;

  // The clear edge wins over a write in the same cycle, since the pin
  // reinitialises the whole register. Standby has no effect here.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      system_control <= ORAC_SYSCTL_RESET; // [R4] [R10]
    end else if (clr_rise) begin
      system_control <= ORAC_SYSCTL_RESET; // [R5]
    end else if (apb_write) begin
      system_control <= pwdata[7:0]; // [R10]
    end
  end

  // Read data are captured in the setup cycle so they come from a flop.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (apb_setup) begin
      prdata <= next_prdata;
    end
  end

  // ----------------------------------------------------------------------
  // Access decode and gating.
  // ----------------------------------------------------------------------
  orac_state_t state;
  orac_state_t next_state;

  wire win_hit  = in_window(mode, cpu_addr); // [R6] [R7]
  wire expanded = (mode == ORAC_MODE_1) || (mode == ORAC_MODE_3) ||
                  (mode == ORAC_MODE_5);
  wire single   = (mode == ORAC_MODE_6) || (mode == ORAC_MODE_7);
  wire idle     = (state == ORAC_IDLE);
  wire req_hit  = idle && cpu_req && win_hit;
  // The enable bit is looked at in the very cycle of the request.
  wire ram_on   = req_hit && onchip_memory_enable; // [R6] [R11]
  wire blocked  = req_hit && !onchip_memory_enable && single; // [R9]
  wire take     = ram_on || blocked;

  // Expanded modes hand a disabled window to external space.
  assign cpu_ext = req_hit && !onchip_memory_enable && expanded; // [R8]

  // Byte lanes: an even byte is the high half of the word.
  wire [ORAC_IDX_W-1:0] ram_idx;
  wire [11:0]           ram_off;
  wire [1:0]            ram_be;
  wire [15:0]           ram_wdata;
  wire                  ram_we;
  wire                  lo_to_hi;

  assign ram_off   = cpu_addr[11:0] - ORAC_LOW_OFFSET;
  assign ram_idx   = ram_off[11:1];
  // A word is always taken from the even address below.
  assign ram_be    = cpu_word    ? 2'b11 :
                     cpu_addr[0] ? 2'b01 : 2'b10; // [R2] [R3]
  assign ram_wdata = cpu_word ? cpu_wdata
                              : {cpu_wdata[15:8], cpu_wdata[15:8]}; // [R2]
  assign ram_we    = ram_on && cpu_write; // [R9]
  assign lo_to_hi  = !cpu_word && cpu_addr[0]; // [R2]

  // ----------------------------------------------------------------------
  // Access sequencer: request state, then answer state.
  // ----------------------------------------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      ORAC_IDLE: begin
        if (take) begin
          next_state = ORAC_ACCESS;
        end
      end
      ORAC_ACCESS: begin
        next_state = ORAC_IDLE;
      end
      default: begin
        next_state = ORAC_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ORAC_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Every internal access completes in the second state.
  assign cpu_ack = (state == ORAC_ACCESS); // [R1] [R2] [R3]

  // ----------------------------------------------------------------------
  // Storage.
  // ----------------------------------------------------------------------
  orac_ram u_ram (
    .pclk       (pclk),
    .presetn    (presetn),
    .en         (ram_on),
    .we         (ram_we),
    .be         (ram_be),
    .idx        (ram_idx),
    .wdata      (ram_wdata),
    .lo_to_hi   (lo_to_hi),
    .force_ones (blocked && !cpu_write), // [R9]
    .rdata      (cpu_rdata)
  );

  // ----------------------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_take_read;
    take && !cpu_write;
  endsequence

  sequence s_answer;
    cpu_ack ##1 !cpu_ack;
  endsequence

  chk_two_state_ack: assert property ( // [R1] [R2] [R3]
    take |=> s_answer)
    else $error("Internal access did not answer in the second state.");

  chk_ack_has_cause: assert property ( // [R1]
    cpu_ack |-> $past(take))
    else $error("Acknowledge without a taken request.");

  chk_byte_lanes: assert property ( // [R2]
    ram_on && !cpu_word |-> $onehot(ram_be))
    else $error("Byte access did not select exactly one lane.");

  chk_word_lanes: assert property ( // [R3]
    ram_on && cpu_word |-> (ram_be == 2'b11))
    else $error("Word access did not use both lanes.");

  chk_clear_reload: assert property ( // [R5]
    clr_rise |=> (system_control == ORAC_SYSCTL_RESET))
    else $error("Clear edge did not reload the control register.");

  chk_reg_write: assert property ( // [R10]
    apb_write && !clr_rise |=> (system_control == $past(pwdata[7:0])))
    else $error("Control register write was not stored.");

  chk_reg_read: assert property ( // [R10]
    apb_setup && reg_hit && !apb_write
      |=> (prdata[7:0] == $past(system_control)))
    else $error("Control register read returned a wrong value.");

  chk_window_top: assert property ( // [R6] [R7]
    req_hit |-> ((mode == ORAC_MODE_3) ? (cpu_addr <= ORAC_M3_TOP) :
                 (mode == ORAC_MODE_6) ? (cpu_addr[15:0] <= ORAC_M6_TOP) :
                 (cpu_addr[19:0] <= ORAC_M157_TOP)))
    else $error("Window hit above the top address.");

  chk_ext_when_off: assert property ( // [R8]
    cpu_req && idle && win_hit && expanded && !system_control[0]
      |-> cpu_ext && !take)
    else $error("Disabled window in expanded mode not sent outside.");

  chk_blocked_ones: assert property ( // [R9]
    s_take_read and blocked |=> (cpu_rdata == ORAC_ALL_ONES) && cpu_ack)
    else $error("Blocked read did not return all ones.");

  chk_blocked_nowrite: assert property ( // [R9] [R11]
    cpu_req && idle && !system_control[0] |-> !ram_we && !ram_on)
    else $error("RAM touched while disabled.");

  // Read data paths, checked against the array word that was addressed.
  sequence s_word_read;
    ram_on && !cpu_write && cpu_word;
  endsequence

  chk_word_rdata: assert property ( // [R1] [R3]
    s_word_read |=> (cpu_rdata == $past(u_ram.cur_word)))
    else $error("Word read returned a wrong value.");

  chk_even_rdata: assert property ( // [R2]
    ram_on && !cpu_write && !cpu_word && !cpu_addr[0]
      |=> (cpu_rdata[15:8] == $past(u_ram.cur_word[15:8])))
    else $error("Even byte read not on the upper lines.");

  chk_odd_rdata: assert property ( // [R2]
    ram_on && !cpu_write && lo_to_hi
      |=> (cpu_rdata[15:8] == $past(u_ram.cur_word[7:0])))
    else $error("Odd byte read not on the upper lines.");

  chk_word_wdata: assert property ( // [R3]
    ram_we && cpu_word |-> (ram_wdata == cpu_wdata))
    else $error("Word write data not passed on all lines.");

  chk_byte_wdata: assert property ( // [R2]
    ram_we && !cpu_word
      |-> (ram_wdata == {cpu_wdata[15:8], cpu_wdata[15:8]}))
    else $error("Byte write data not taken from the upper lines.");

  chk_even_lane: assert property ( // [R2]
    ram_on && !cpu_word && !cpu_addr[0] |-> (ram_be == 2'b10))
    else $error("Even byte access did not use the upper lane.");

  chk_miss_ignored: assert property ( // [R6] [R7]
    cpu_req && idle && !win_hit |-> !take && !cpu_ext)
    else $error("Access outside the window was answered.");

  chk_enabled_ram: assert property ( // [R6] [R11]
    req_hit && onchip_memory_enable |-> ram_on && !cpu_ext)
    else $error("Enabled window access did not reach the RAM.");

  chk_single_block: assert property ( // [R9]
    req_hit && single && !onchip_memory_enable |-> take && !cpu_ext)
    else $error("Disabled single-chip access was not answered.");

  chk_busy_ignored: assert property ( // [R2] [R3]
    cpu_req && !idle |-> !take && !cpu_ext)
    else $error("Request taken during the answer state.");

  chk_reg_hold: assert property ( // [R4] [R10]
    !apb_write && !clr_rise |=> $stable(system_control))
    else $error("Control register changed with no write or clear.");

  chk_standby_keep: assert property ( // [R5]
    stby_sync && !apb_write && !clr_rise |=> $stable(system_control))
    else $error("Control register lost its value in standby.");

  chk_mode6_base: assert property ( // [R7]
    req_hit && (mode == ORAC_MODE_6) |-> (cpu_addr[15:0] >= ORAC_M6_BASE))
    else $error("Mode 6 window hit below its base.");

endmodule // orac_ctrl
`default_nettype wire

// ===== logic/orac_pkg.sv
// Package of constants and types for the on-chip RAM access control block.
package orac_pkg;

  // ----------------------------------------------------------------------
  // System control register.
  // ----------------------------------------------------------------------
  localparam logic [15:0] ORAC_SYSCTL_INDEX = 16'hFFF2;
  localparam logic [31:0] ORAC_SYSCTL_ADDR  = {14'h0000, ORAC_SYSCTL_INDEX,
                                               2'b00};
  localparam logic [7:0]  ORAC_SYSCTL_RESET = 8'h0B;
  localparam int          ORAC_ENABLE_BIT   = 0;

  // ----------------------------------------------------------------------
  // RAM geometry and address windows.
  // ----------------------------------------------------------------------
  localparam int          ORAC_WORDS        = 2048;
  localparam int          ORAC_IDX_W        = 11;
  localparam logic [11:0] ORAC_LOW_OFFSET   = 12'hF10;
  localparam logic [19:0] ORAC_M157_BASE    = 20'hFEF10;
  localparam logic [19:0] ORAC_M157_TOP     = 20'hFFF0F;
  localparam logic [23:0] ORAC_M3_BASE      = 24'hFFEF10;
  localparam logic [23:0] ORAC_M3_TOP       = 24'hFFFF0F;
  localparam logic [15:0] ORAC_M6_BASE      = 16'hF710;
  localparam logic [15:0] ORAC_M6_TOP       = 16'hFF0F;
  localparam logic [15:0] ORAC_ALL_ONES     = 16'hFFFF;

  // ----------------------------------------------------------------------
  // Operating modes as set on the mode pins.
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    ORAC_MODE_0 = 3'b000,
    ORAC_MODE_1 = 3'b001,
    ORAC_MODE_2 = 3'b010,
    ORAC_MODE_3 = 3'b011,
    ORAC_MODE_4 = 3'b100,
    ORAC_MODE_5 = 3'b101,
    ORAC_MODE_6 = 3'b110,
    ORAC_MODE_7 = 3'b111
  } orac_mode_t;

  // Access sequencer states.
  typedef enum logic [1:0] {
    ORAC_IDLE   = 2'b00,
    ORAC_ACCESS = 2'b01
  } orac_state_t;

endpackage : orac_pkg

// ===== logic/orac_ram.sv
// Word-wide static RAM with byte lanes, registered read and lane steering.
`timescale 1ns/1ps
`default_nettype none
module orac_ram (
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  input  wire logic                          en,
  input  wire logic                          we,
  input  wire logic [1:0]                    be,
  input  wire logic [orac_pkg::ORAC_IDX_W-1:0] idx,
  input  wire logic [15:0]                   wdata,
  input  wire logic                          lo_to_hi,
  input  wire logic                          force_ones,
  output logic      [15:0]                   rdata
);
  import orac_pkg::*;

  logic [15:0] mem [0:ORAC_WORDS-1];
  wire  [15:0] cur_word = mem[idx];
  wire  [15:0] steered  = lo_to_hi ? {cur_word[7:0], cur_word[7:0]}
                                   : cur_word;

  // ----------------------------------------------------------------------
  // Storage.
  // ----------------------------------------------------------------------
  // The array has no reset; its contents are undefined until written.
  always_ff @(posedge pclk) begin
    if (en && we && be[1]) begin
      mem[idx][15:8] <= wdata[15:8];
    end
    if (en && we && be[0]) begin
      mem[idx][7:0] <= wdata[7:0];
    end
  end

  // Read data register; a blocked access reads as all ones.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata <= 16'h0000;
    end else if (force_ones) begin
      rdata <= ORAC_ALL_ONES;
    end else if (en && !we) begin
      rdata <= steered;
    end
  end

endmodule // orac_ram
`default_nettype wire

// ===== tb/orac_cpu_model.sv
// CPU core model that drives the internal bus of the RAM access block.
`timescale 1ns/1ps
`default_nettype none
module orac_cpu_model (
  input  wire logic        pclk,
  input  wire logic        cpu_ack,
  input  wire logic        cpu_ext,
  input  wire logic [15:0] cpu_rdata,
  output logic             cpu_req,
  output logic             cpu_write,
  output logic             cpu_word,
  output logic      [23:0] cpu_addr,
  output logic      [15:0] cpu_wdata
);
  // Idle bus at time zero.
  initial begin
    cpu_req   = 1'b0;
    cpu_write = 1'b0;
    cpu_word  = 1'b0;
    cpu_addr  = 24'h000000;
    cpu_wdata = 16'h0000;
  end

  // One access, held until ack or external steering; gives up after six
  // edges, since a miss outside the window never answers.
  task automatic access(input logic w, input logic wd, input logic [23:0] a,
                        input logic [15:0] d, output logic [15:0] rd,
                        output int at);
    at = 0;
    rd = 16'h0000;
    @(posedge pclk);
    cpu_req   <= 1'b1;
    cpu_write <= w;
    cpu_word  <= wd;
    cpu_addr  <= a;
    cpu_wdata <= d;
    for (int i = 1; i <= 6 && at == 0; i++) begin
      @(posedge pclk);
      if (cpu_ack === 1'b1) begin
        at = i;
        rd = cpu_rdata;
      end
      else if (cpu_ext === 1'b1) at = 100;
    end
    // Released lines show the inverse so a stale value cannot pass.
    cpu_req   <= 1'b0;
    cpu_addr  <= ~a;
    cpu_wdata <= ~d;
  endtask
endmodule // orac_cpu_model
`default_nettype wire

// ===== tb/onchip_ram_access_control_tb.sv
// Self-checking bench for the on-chip RAM access control block.
`timescale 1ns/1ps
`default_nettype none
module onchip_ram_access_control_tb;
  import orac_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [31:0] paddr, pwdata, prdata;
  logic        hardware_clear_input_n, standby;
  logic [2:0]  mode_pins;
  logic        cpu_req, cpu_write, cpu_word, cpu_ack, cpu_ext;
  logic [23:0] cpu_addr;
  logic [15:0] cpu_wdata, cpu_rdata;
  logic [7:0]  reg_m;
  logic [15:0] mem [int];
  int          n_fail, compares;

  orac_ctrl DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .hardware_clear_input_n, .mode_pins,
    .standby, .cpu_req, .cpu_write, .cpu_word, .cpu_addr, .cpu_wdata,
    .cpu_rdata, .cpu_ack, .cpu_ext);
  orac_cpu_model cpu (.pclk, .cpu_ack, .cpu_ext, .cpu_rdata, .cpu_req,
    .cpu_write, .cpu_word, .cpu_addr, .cpu_wdata);

  // --------------------------------------------------------------------
  // Shared tasks.
  // --------------------------------------------------------------------
  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // APB transfer; request held until pready is seen high.
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Wait as long as the slave asks; only the watchdog ends a hang.
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] v);
    logic [31:0] rd;
    logic        err;
    apb(1'b0, ORAC_SYSCTL_ADDR, 32'h0, rd, err);
    check({7'h0, err, rd}, {8'h0, 24'h0, v});
  endtask

  task automatic reg_wr(input logic [7:0] v);
    logic [31:0] rd;
    logic        err;
    apb(1'b1, ORAC_SYSCTL_ADDR, {24'h0, v}, rd, err);
    reg_m = v;
    reg_rd(v);
  endtask

  // Window test of the model, taken from the mode address map.
  function automatic bit inwin(logic [2:0] m, logic [23:0] a);
    case (m)
      3'd3: return a >= 24'hFFEF10 && a <= 24'hFFFF0F;
      3'd6: return a[15:0] >= 16'hF710 && a[15:0] <= 16'hFF0F;
      3'd1, 3'd5, 3'd7: return a[19:0] >= 20'hFEF10 && a[19:0] <= 20'hFFF0F;
      default: return 1'b0;
    endcase
  endfunction

  // One CPU access compared against the memory model.
  task automatic cpu_op(input logic w, input logic wd, input logic [23:0] a,
                        input logic [15:0] d);
    logic [15:0] rd, ev;
    logic [11:0] o;
    int          at, k;
    bit          win, ext, lo;
    o = a[11:0] - 12'hF10;
    k = int'(o[11:1]);
    win = inwin(mode_pins, a);
    ext = win && !reg_m[0] && (mode_pins inside {3'd1, 3'd3, 3'd5});
    lo = a[0];
    cpu.access(w, wd, a, d, rd, at);
    check(40'(at), 40'(!win ? 0 : ext ? 100 : 2));
    if (win && reg_m[0] && w) begin
      if (wd) mem[k] = d;
      else if (lo) mem[k][7:0] = d[15:8];
      else mem[k][15:8] = d[15:8];
    end
    if (win && !ext && !w && (!reg_m[0] || mem.exists(k))) begin
      ev = reg_m[0] ? mem[k] : 16'hFFFF;
      if (wd) check(40'(rd), 40'(ev));
      else check(40'(rd[15:8]), 40'(lo ? ev[7:0] : ev[15:8]));
    end
  endtask

  // --------------------------------------------------------------------
  // Clock, watchdog and main sequence.
  // --------------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // About 1000 cycles are expected; the limit leaves wide margin.
  initial begin
    #500000;
    n_fail++;
    give_verdict();
  end

  initial begin : main
    logic [31:0] rd;
    logic        err;
    logic [2:0]  modes [5];
    int          base, sz, off;
    logic [15:0] d;
    modes = '{3'd1, 3'd3, 3'd5, 3'd6, 3'd7};
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    hardware_clear_input_n = 1'b1;
    standby = 1'b0;
    mode_pins = 3'd1;
    reg_m = 8'h0B;
    void'($urandom(81876));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    reg_rd(8'h0B);
    // Unmapped place: error flagged, reads zero, write ignored.
    apb(1'b1, 32'h0000_0010, 32'h0000_00FF, rd, err);
    apb(1'b0, 32'h0000_0010, 32'h0, rd, err);
    check({7'h0, err, rd}, {8'h01, 32'h0});
    foreach (modes[j]) begin
      mode_pins <= modes[j];
      repeat (4) @(posedge pclk);
      base = (modes[j] == 3'd3) ? 'hFFEF10 : (modes[j] == 3'd6) ? 'hF710
             : 'hFEF10;
      sz = (modes[j] == 3'd6) ? 'h800 : 'h1000;
      for (int e = 1; e >= 0; e--) begin
        reg_wr({8'($urandom) & 8'hFE} | 8'(e));
        cpu_op(1'b0, 1'b1, 24'(base), 16'h0);
        for (int i = 0; i < 6; i++) begin
          off = (i == 0) ? 0 : (i == 1) ? sz - 2 : int'($urandom % sz) & ~1;
          d = 16'($urandom);
          cpu_op(1'b1, 1'b1, 24'(base + off), d);
          cpu_op(1'b1, 1'b0, 24'(base + off + (i & 1)), ~d);
          cpu_op(1'b0, 1'b1, 24'(base + off), 16'h0);
          cpu_op(1'b0, 1'b0, 24'(base + off + (~i & 1)), 16'h0);
        end
        cpu_op(1'b0, 1'b1, 24'(base - 1), 16'h0);
        cpu_op(1'b0, 1'b1, 24'(base + sz), 16'h0);
      end
    end
    // Standby keeps the register; the clear pin reloads it.
    reg_wr(8'h00);
    standby <= 1'b1;
    repeat (4) @(posedge pclk);
    reg_rd(8'h00);
    standby <= 1'b0;
    hardware_clear_input_n <= 1'b0;
    repeat (3) @(posedge pclk);
    hardware_clear_input_n <= 1'b1;
    repeat (6) @(posedge pclk);
    reg_m = 8'h0B;
    reg_rd(8'h0B);
    cpu_op(1'b0, 1'b1, 24'hFEF10, 16'h0);
    // Mid-run reset; a write in the first edges after release must stick.
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    reg_m = 8'h0B;
    d = 16'($urandom);
    reg_wr(d[7:0] | 8'h01);
    repeat (2) @(posedge pclk);
    cpu_op(1'b0, 1'b1, 24'hFEF10, 16'h0);
    give_verdict();
  end
endmodule // onchip_ram_access_control_tb
`default_nettype wire
